// *** pkg/disp_i2c_pkg.sv ***
// constants and types shared by the display driver serial write slave
`default_nettype none
package disp_i2c_pkg;

    // ---------------------------------------------------------------
    // slave address and byte layout
    // ---------------------------------------------------------------
    localparam logic [5:0] ADDR_UPPER = 6'h1e;  // upper six address bits, 011110
    localparam logic RW_WRITE = 1'b0;
    localparam int RW_BIT = 0;
    localparam int CONT_BIT = 7;                // continuation_flag
    localparam int RAM_SEL_BIT = 6;             // ram_select_flag, control_bit_six
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;

    // ---------------------------------------------------------------
    // display data pointer
    // ---------------------------------------------------------------
    localparam int PTR_W = 11;
    localparam logic [PTR_W-1:0] PTR_RESET = 11'h000;
    localparam logic [PTR_W-1:0] PTR_STEP = 11'h001;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ---------------------------------------------------------------
    // state encodings
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RECV = 2'b01,
        ST_ACK = 2'b10,
        ST_IGNORE = 2'b11
    } link_state_t;

    typedef enum logic [1:0] {
        K_ADDR = 2'b00,
        K_CTRL = 2'b01,
        K_DATA = 2'b10
    } byte_kind_t;

    // ---------------------------------------------------------------
    // carriers toward display RAM and command decoder
    // ---------------------------------------------------------------
    typedef struct packed {
        logic we;
        logic [PTR_W-1:0] addr;
        logic [7:0] data;
    } ram_wr_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } cmd_t;

endpackage
`default_nettype wire

// *** src/display_driver_i2c_write_slave.sv ***
// write-only two-wire serial slave with control byte decoder for a display driver
`timescale 1ns/10ps
`default_nettype none
module display_driver_i2c_write_slave
    import disp_i2c_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,

    // serial bus pins, open drain data
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,

    // static strap
    input wire logic address_select_input_i,

    // pointer load from the command decoder, same clock
    input wire logic ptr_load_i,
    input wire logic [PTR_W-1:0] ptr_value_i,

    // display RAM write port
    output logic ram_we_o,
    output logic [PTR_W-1:0] ram_addr_o,
    output logic [7:0] ram_wdata_o,

    // command decoder port
    output logic cmd_valid_o,
    output logic [7:0] cmd_data_o,

    // status
    output logic addressed_o,
    output logic [PTR_W-1:0] data_ptr_o
);

    // ---------------------------------------------------------------
    // state record
    // ---------------------------------------------------------------
    typedef struct packed {
        logic scl_prev;
        logic sda_prev;
        link_state_t state;
        byte_kind_t kind;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic cont;
        logic ram_sel;
        logic drive_low;
        logic addressed;
        logic [PTR_W-1:0] ptr;
        ram_wr_t ram;
        cmd_t cmd;
    } slave_state_t;

    slave_state_t s_q;
    slave_state_t s_d;

    // ---------------------------------------------------------------
    // pin conditioning and bus events
    // ---------------------------------------------------------------
    logic scl;
    logic sda;
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
    logic [7:0] rx_byte;
    logic addr_match;

    // only the second stage of each synchroniser is used from here on
    // both pins idle high, so the stages reset high and no false edge follows reset
    disp_pin_sync #(
        .IDLE_LEVEL(1'b1)
    ) scl_sync_inst (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(scl_i),
        .level_o(scl)
    );

    disp_pin_sync #(
        .IDLE_LEVEL(1'b1)
    ) sda_sync_inst (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(sda_i),
        .level_o(sda)
    );

    assign start_seen = scl && s_q.scl_prev && s_q.sda_prev && !sda;
    assign stop_seen = scl && s_q.scl_prev && !s_q.sda_prev && sda;
    assign scl_rise = scl && !s_q.scl_prev;
    assign scl_fall = !scl && s_q.scl_prev;
    assign rx_byte = s_q.shift;

    // strap is static, so reading it straight into the compare is safe
    assign addr_match = (rx_byte[7:2] == ADDR_UPPER) &&
                        (rx_byte[1] == address_select_input_i) &&
                        (rx_byte[RW_BIT] == RW_WRITE);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.scl_prev = scl;
        s_d.sda_prev = sda;
        s_d.ram.we = 1'b0;
        s_d.cmd.valid = 1'b0;

        if (start_seen) begin
            // repeated start drops the message but keeps the pointer
            s_d.state = ST_RECV;
            s_d.kind = K_ADDR;
            s_d.bit_cnt = BIT_CNT_RESET;
            s_d.drive_low = 1'b0;
            s_d.addressed = 1'b0;
        end else if (stop_seen) begin
            s_d.state = ST_IDLE;
            s_d.drive_low = 1'b0;
            s_d.addressed = 1'b0;
        end else begin
            case (s_q.state)
                ST_IDLE: begin
                    s_d.drive_low = 1'b0;
                end
                ST_RECV: begin
                    if (scl_rise && s_q.bit_cnt < BITS_PER_BYTE) begin
                        s_d.shift = {s_q.shift[6:0], sda};
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end else if (scl_fall && s_q.bit_cnt == BITS_PER_BYTE) begin
                        case (s_q.kind)
                            K_ADDR: begin
                                if (addr_match) begin
                                    s_d.state = ST_ACK;
                                    s_d.drive_low = 1'b1;
                                    s_d.addressed = 1'b1;
                                    s_d.kind = K_CTRL;
                                end else begin
                                    s_d.state = ST_IGNORE;
                                end
                            end
                            K_CTRL: begin
                                s_d.cont = rx_byte[CONT_BIT];
                                s_d.ram_sel = rx_byte[RAM_SEL_BIT];
                                s_d.kind = K_DATA;
                                s_d.state = ST_ACK;
                                s_d.drive_low = 1'b1;
                            end
                            K_DATA: begin
                                if (s_q.ram_sel) begin
                                    s_d.ram.we = 1'b1;
                                    s_d.ram.addr = s_q.ptr;
                                    s_d.ram.data = rx_byte;
                                    s_d.ptr = s_q.ptr + PTR_STEP;
                                end else begin
                                    s_d.cmd.valid = 1'b1;
                                    s_d.cmd.data = rx_byte;
                                end
                                // stream mode stays on data until the message ends
                                s_d.kind = s_q.cont ? K_CTRL : K_DATA;
                                s_d.state = ST_ACK;
                                s_d.drive_low = 1'b1;
                            end
                            default: begin
                                s_d.state = ST_IGNORE;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    // hold the line low through the whole ninth clock
                    if (scl_fall) begin
                        s_d.drive_low = 1'b0;
                        s_d.bit_cnt = BIT_CNT_RESET;
                        s_d.shift = BYTE_RESET;
                        s_d.state = ST_RECV;
                    end
                end
                ST_IGNORE: begin
                    s_d.drive_low = 1'b0;
                end
                default: begin
                    s_d.state = ST_IDLE;
                    s_d.drive_low = 1'b0;
                end
            endcase
        end

        // decoder write to the pointer loses to an advance in the same cycle
        if (ptr_load_i && !(s_d.ram.we)) begin
            s_d.ptr = ptr_value_i;
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q.scl_prev <= 1'b1;
            s_q.sda_prev <= 1'b1;
            s_q.state <= ST_IDLE;
            s_q.kind <= K_ADDR;
            s_q.bit_cnt <= BIT_CNT_RESET;
            s_q.shift <= BYTE_RESET;
            s_q.cont <= 1'b0;
            s_q.ram_sel <= 1'b0;
            s_q.drive_low <= 1'b0;
            s_q.addressed <= 1'b0;
            s_q.ptr <= PTR_RESET;
            s_q.ram <= '0;
            s_q.cmd <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all but the tied-low sda_o straight from the state register
    // ---------------------------------------------------------------
    // the pin is only ever pulled low; the high level comes from the pull-up
    assign sda_o = 1'b0;
    assign sda_oe_n_o = !s_q.drive_low;
    assign ram_we_o = s_q.ram.we;
    assign ram_addr_o = s_q.ram.addr;
    assign ram_wdata_o = s_q.ram.data;
    assign cmd_valid_o = s_q.cmd.valid;
    assign cmd_data_o = s_q.cmd.data;
    assign addressed_o = s_q.addressed;
    assign data_ptr_o = s_q.ptr;

endmodule

// ---------------------------------------------------------------
// two flop synchroniser for one bus pin
// ---------------------------------------------------------------
// no glitch filter: a spike longer than one clock is seen as a real level
module disp_pin_sync
    import disp_i2c_pkg::*;
#(
    parameter logic IDLE_LEVEL = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,

    // raw pin and its synchronised level
    input wire logic pin_i,
    output logic level_o
);

    typedef struct packed {
        logic [1:0] stages;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    // the first stage feeds nothing but the second
    always_comb begin
        s_d = s_q;
        s_d.stages = {s_q.stages[0], pin_i};
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q.stages <= {2{IDLE_LEVEL}};
        end else begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.stages[1];

endmodule
`default_nettype wire

// *** dv/display_driver_i2c_write_slave_sva.sv ***
// port assertions for the display serial write slave
`timescale 1ns/10ps
`default_nettype none
module display_driver_i2c_write_slave_sva
    import disp_i2c_pkg::*;
(
    // clock, reset and serial pins
    input wire logic clk_i, rst_n_i, scl_i, sda_i, sda_o, sda_oe_n_o,
    // strap and pointer load
    input wire logic address_select_input_i, ptr_load_i,
    input wire logic [PTR_W-1:0] ptr_value_i, ram_addr_o, data_ptr_o,
    // write ports and status
    input wire logic ram_we_o, cmd_valid_o, addressed_o,
    input wire logic [7:0] ram_wdata_o, cmd_data_o
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_drive_low_only: assert property (!sda_oe_n_o |-> !sda_o)
        else $error("data line driven high");
    a_ack_needs_addr: assert property (!sda_oe_n_o |-> addressed_o)
        else $error("ack while not addressed");
    a_ram_byte_acked: assert property (ram_we_o |-> !sda_oe_n_o && addressed_o)
        else $error("ram byte not acked");
    a_cmd_byte_acked: assert property (cmd_valid_o |-> !sda_oe_n_o && addressed_o)
        else $error("command byte not acked");
    a_one_target: assert property (ram_we_o |-> !cmd_valid_o ##1 !ram_we_o)
        else $error("ram strobe overlaps");
    a_ram_at_ptr: assert property (ram_we_o && !$past(ptr_load_i)
        |-> ram_addr_o == $past(data_ptr_o)) else $error("ram write off pointer");
    a_ptr_advance: assert property (ram_we_o |-> data_ptr_o == ram_addr_o + PTR_STEP)
        else $error("pointer not advanced");
    a_ptr_load_taken: assert property (ptr_load_i |=> ram_we_o || data_ptr_o == $past(ptr_value_i))
        else $error("pointer load lost");
    a_cmd_keeps_ptr: assert property (cmd_valid_o && !$past(ptr_load_i)
        |-> $stable(data_ptr_o)) else $error("command moved pointer");
    a_stop_release: assert property (scl_i && $rose(sda_i) |-> ##[1:6] !addressed_o)
        else $error("stop did not release");
    a_start_release: assert property (scl_i && $fell(sda_i) |-> ##[1:6] !addressed_o)
        else $error("start did not release");
    c_ram_write: cover property (ram_we_o);
    c_cmd_write: cover property (cmd_valid_o);
    c_restart: cover property (addressed_o && scl_i && $fell(sda_i));
endmodule
bind display_driver_i2c_write_slave display_driver_i2c_write_slave_sva
    display_driver_i2c_write_slave_sva_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .ptr_load_i(ptr_load_i),
    .address_select_input_i(address_select_input_i), .ptr_value_i(ptr_value_i),
    .ram_addr_o(ram_addr_o), .data_ptr_o(data_ptr_o), .ram_we_o(ram_we_o),
    .cmd_valid_o(cmd_valid_o), .addressed_o(addressed_o), .ram_wdata_o(ram_wdata_o),
    .cmd_data_o(cmd_data_o));
`default_nettype wire

// *** dv/i2c_master_model.sv ***
// behavioural two-wire bus master for the slave's serial pins
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
    // clock and the slave's open-drain drive
    input wire logic clk_i, sda_o_i, sda_oe_n_i,
    // bus lines as seen at the pins
    output var logic scl_o,
    output logic sda_bus_o
);
    logic sda_m;
    // pull-up: reads high unless someone pulls low
    assign sda_bus_o = sda_m & (sda_oe_n_i | sda_o_i);
    initial begin
        scl_o = 1'b1;
        sda_m = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic bit_out(input logic b);
        scl_o <= 1'b0;
        tick(2);
        sda_m <= b;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
    endtask
    // low phase after the ack is stretched so the slave lets go first
    task automatic wbyte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_out(1'b1);
        ack = sda_bus_o;
        scl_o <= 1'b0;
        tick(6);
    endtask
    task automatic start();
        sda_m <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_m <= 1'b0;
        tick(4);
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_m <= 1'b1;
        tick(8);
    endtask
endmodule
`default_nettype wire

// *** dv/test_display_driver_i2c_write_slave.sv ***
// self-checking bench for the display serial write slave
`timescale 1ns/10ps
`default_nettype none
module test_display_driver_i2c_write_slave;
    import disp_i2c_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic strap = 1'b0;
    logic ptr_load = 1'b0;
    logic [PTR_W-1:0] ptr_val = PTR_RESET;
    logic scl, sda, sda_o, sda_oe_n, ram_we, cmd_valid, addressed;
    logic [PTR_W-1:0] ram_addr, data_ptr;
    logic [7:0] ram_wdata, cmd_data;
    logic [19:0] wr_q[$];
    int n_errors = 0;
    int comparisons = 0;
    always #5 clk_i = ~clk_i;
    display_driver_i2c_write_slave display_driver_i2c_write_slave_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n), .address_select_input_i(strap), .ptr_load_i(ptr_load),
        .ptr_value_i(ptr_val), .ram_we_o(ram_we), .ram_addr_o(ram_addr),
        .ram_wdata_o(ram_wdata), .cmd_valid_o(cmd_valid), .cmd_data_o(cmd_data),
        .addressed_o(addressed), .data_ptr_o(data_ptr));
    i2c_master_model i2c_master_model_inst (.clk_i(clk_i), .sda_o_i(sda_o),
        .sda_oe_n_i(sda_oe_n), .scl_o(scl), .sda_bus_o(sda));
    // ------------------------------------------------------------
    // write log: ram (1) or command (0)
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (ram_we === 1'b1) wr_q.push_back({1'b1, ram_addr, ram_wdata});
        if (cmd_valid === 1'b1) wr_q.push_back({1'b0, PTR_RESET, cmd_data});
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic ack;
        i2c_master_model_inst.wbyte(d, ack);
        chk("ack", 32'(exp_ack), 32'(ack));
    endtask
    task automatic exp_wr(input logic [19:0] e);
        if (wr_q.size() == 0) chk("write count", 32'h1, 32'h0);
        else chk("write", 32'(e), 32'(wr_q.pop_front()));
    endtask
    task automatic t_ram_stream();
        i2c_master_model_inst.start();
        send(8'h78, 1'b0);
        send(8'h40, 1'b0);
        send(8'ha5, 1'b0);
        send(8'h3c, 1'b0);
        i2c_master_model_inst.stop();
        exp_wr({1'b1, 11'h000, 8'ha5});
        exp_wr({1'b1, 11'h001, 8'h3c});
        chk("addressed", 32'h0, 32'(addressed));
        $display("test ram stream done");
    endtask
    task automatic t_pairs();
        i2c_master_model_inst.start();
        send(8'h78, 1'b0);
        send(8'h80, 1'b0);
        send(8'h21, 1'b0);
        send(8'hc0, 1'b0);
        send(8'h77, 1'b0);
        send(8'h00, 1'b0);
        send(8'h11, 1'b0);
        send(8'h12, 1'b0);
        i2c_master_model_inst.stop();
        exp_wr({1'b0, 11'h000, 8'h21});
        exp_wr({1'b1, 11'h002, 8'h77});
        exp_wr({1'b0, 11'h000, 8'h11});
        exp_wr({1'b0, 11'h000, 8'h12});
        chk("pointer", 32'h3, 32'(data_ptr));
        $display("test command pairs done");
    endtask
    task automatic t_refuse();
        i2c_master_model_inst.start();
        send(8'h7a, 1'b1);
        send(8'h40, 1'b1);
        send(8'h55, 1'b1);
        i2c_master_model_inst.stop();
        i2c_master_model_inst.start();
        send(8'h79, 1'b1);
        send(8'hc0, 1'b1);
        i2c_master_model_inst.stop();
        chk("writes", 32'h0, 32'(wr_q.size()));
        strap <= 1'b1;
        i2c_master_model_inst.start();
        send(8'h7a, 1'b0);
        send(8'h80, 1'b0);
        send(8'h5a, 1'b0);
        i2c_master_model_inst.stop();
        strap <= 1'b0;
        exp_wr({1'b0, 11'h000, 8'h5a});
        $display("test address refusal done");
    endtask
    // pointer parked at the top so the restart also crosses the wrap
    task automatic t_restart();
        ptr_load <= 1'b1;
        ptr_val <= 11'h7ff;
        @(posedge clk_i);
        ptr_load <= 1'b0;
        i2c_master_model_inst.start();
        send(8'h78, 1'b0);
        send(8'h40, 1'b0);
        send(8'h99, 1'b0);
        i2c_master_model_inst.start();
        send(8'h78, 1'b0);
        send(8'h40, 1'b0);
        send(8'h88, 1'b0);
        i2c_master_model_inst.stop();
        exp_wr({1'b1, 11'h7ff, 8'h99});
        exp_wr({1'b1, 11'h000, 8'h88});
        chk("writes", 32'h0, 32'(wr_q.size()));
        $display("test restart done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // about 26 bytes of 80 clocks each; ample margin
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        t_ram_stream();
        t_pairs();
        t_refuse();
        t_restart();
        report_and_stop();
    end
endmodule
`default_nettype wire
